// ### src/front_main_pkg.sv
package front_main_pkg;

	// ----------------------------------------
	// scratch ram layout
	// ----------------------------------------
	localparam int          RAM_WORDS  = 16;
	localparam int          WORD_W     = 16;
	localparam logic [3:0]  LOC_DELAY  = 4'h0;
	localparam logic [3:0]  LOC_COUNT  = 4'h6;
	localparam logic [3:0]  LOC_ADDR   = 4'hA;
	localparam logic [3:0]  LOC_DATA   = 4'hC;

	// ----------------------------------------
	// register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [5:0]  IDX_MODE   = 6'h10;
	localparam logic [5:0]  IDX_STATUS = 6'h11;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int          MODE_BIT   = 0;
	localparam int          CNT_SIGN   = 13;
	localparam int          CNT_IBIT   = 14;
	localparam int          ST_DONE    = 0;
	localparam int          ST_FRONT   = 1;
	localparam int          ST_MODE    = 2;
	localparam int          ST_BUSY    = 3;

	// ----------------------------------------
	// reset values and steps
	// ----------------------------------------
	localparam logic [15:0] RST_WORD   = 16'h0000;
	localparam logic [31:0] RST_RDATA  = 32'h0000_0000;
	localparam logic [15:0] STEP_ONE   = 16'h0001;
	localparam logic [15:0] STEP_BYTE  = 16'h0001;
	localparam logic [15:0] STEP_WORD  = 16'h0002;

	typedef enum logic [9:0] {
		ST_IDLE      = 10'b00_0000_0001,
		ST_DLY_LOAD  = 10'b00_0000_0010,
		ST_DLY_INC   = 10'b00_0000_0100,
		ST_BC_TEST   = 10'b00_0000_1000,
		ST_BC_ADD    = 10'b00_0001_0000,
		ST_ADR_FETCH = 10'b00_0010_0000,
		ST_BUS_READ  = 10'b00_0100_0000,
		ST_STORE     = 10'b00_1000_0000,
		ST_ADR_INC   = 10'b01_0000_0000,
		ST_MAIN_WAIT = 10'b10_0000_0000
	} state_type;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} front_req_type;

	typedef struct packed {
		logic        ack;
		logic [15:0] data;
	} front_rsp_type;

endpackage

// ### src/front_to_main_transfer_engine.sv
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// [RULE1] capture mode bit 00 on mode load
// [RULE2] front end loads mode before block
// [RULE3] mode bit 1 selects word mode
// [RULE4] even byte low, upper bits zero
// [RULE5] odd byte swapped into low half
// [RULE6] ram word into buffer bits 20-35
// [RULE7] word mode passes 16 bits straight
// [RULE8] byte mode address steps by one
// [RULE9] word mode address steps by two
// [RULE10] count loaded negative, counts up
// [RULE11] delay increments until bit 13 clear
// [RULE12] count bit 13 clear ends, interrupts main
// [RULE13] count interrupt bit also interrupts front
// [RULE14] nonzero count incremented, written back
// [RULE15] address loaded, front bus read issued
// [RULE16] fetched item stored in slot 12
// [RULE17] address advanced, written back to 10
// [RULE18] fetch first, then request main
// [RULE19] main reads item, releasing the cycle
// [RULE20] no null stop in this direction
// [RULE21] sixteen by sixteen ram, front only
// [RULE22] delay and address preloaded beforehand
// [RULE23] count load launches the block
module front_to_main_transfer_engine
	import front_main_pkg::*;
(
	// clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          rstn,
	// apb register port
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	// front-end bus master read
	output front_main_pkg::front_req_type      front_req,
	input  wire front_main_pkg::front_rsp_type front_rsp,
	// main processor side
	output logic                               main_item_req,
	input  wire logic                          main_read,
	output logic      [0:35]                   main_data,
	output logic                               main_done_irq,
	output logic                               front_done_irq
);
	import front_main_pkg::*;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// carry stops below the interrupt bit so counting to zero keeps it
	function automatic logic [15:0] cnt_inc(input logic [15:0] w);
		logic [13:0] f;
		f = w[13:0] + 14'h0001;
		return {w[15:14], f};
	endfunction

	function automatic logic [15:0] place(input logic word, input logic odd,
		input logic [15:0] d);
		logic [15:0] r;
		r = d;
		if (!word)
			r = odd ? {8'h00, d[15:8]} : {8'h00, d[7:0]};
		return r;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	state_type   state_q;
	logic [15:0] ram_q [RAM_WORDS];
	logic [15:0] abc_q;
	logic [15:0] fetch_q;
	logic [0:35] ebuf_q;
	logic [31:0] prdata_q;
	logic        mode_q;
	logic        start_q;
	logic        done_q;
	logic        front_q;

	logic        eng_we;
	logic [3:0]  eng_idx;
	logic [15:0] eng_wd;
	logic [15:0] step;
	logic [15:0] dly_next;
	logic        term;
	logic [5:0]  idx;
	logic        ram_hit;
	logic        hit;
	logic        apb_wr;
	logic [31:0] rd_mux;

	assign step     = mode_q ? STEP_WORD : STEP_BYTE;
	assign dly_next = abc_q + STEP_ONE;
	assign term     = state_q == ST_BC_TEST && !ram_q[LOC_COUNT][CNT_SIGN];

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	assign idx     = paddr[7:2];
	assign ram_hit = idx < 6'(RAM_WORDS);
	assign hit     = ram_hit || idx == IDX_MODE || idx == IDX_STATUS;
	// ram port is shared, so a bus access waits out an engine write
	assign pready  = !eng_we;
	assign pslverr = psel && penable && !hit;
	assign apb_wr  = psel && penable && pwrite && pready && hit;
	assign prdata  = prdata_q;

	always_comb begin
		rd_mux = RST_RDATA;
		if (ram_hit)
			rd_mux = {16'h0000, ram_q[idx[3:0]]};
		else if (idx == IDX_MODE)
			rd_mux[MODE_BIT] = mode_q;
		else if (idx == IDX_STATUS) begin
			rd_mux[ST_DONE]  = done_q;
			rd_mux[ST_FRONT] = front_q;
			rd_mux[ST_MODE]  = mode_q;
			rd_mux[ST_BUSY]  = state_q != ST_IDLE;
		end
	end

	// read data sampled in setup, held through the access phase
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			prdata_q <= RST_RDATA;
		else if (psel && !penable)
			prdata_q <= rd_mux;
	end

	// ----------------------------------------
	// scratch ram
	// ----------------------------------------
	always_comb begin
		eng_we  = 1'b0;
		eng_idx = LOC_COUNT;
		eng_wd  = abc_q;
		case (state_q)
			ST_BC_ADD: begin
				eng_we = 1'b1; // RULE14
			end
			ST_STORE: begin
				eng_we  = 1'b1; // RULE16
				eng_idx = LOC_DATA;
				eng_wd  = fetch_q;
			end
			ST_ADR_INC: begin
				eng_we  = 1'b1; // RULE17
				eng_idx = LOC_ADDR;
				eng_wd  = abc_q + step;
			end
			default: begin
				eng_we = 1'b0;
			end
		endcase
	end

	// only the apb port and the engine reach it
	always_ff @(posedge sys_clk) begin
		if (eng_we)
			ram_q[eng_idx] <= eng_wd; // RULE21
		else if (apb_wr && ram_hit)
			ram_q[idx[3:0]] <= pwdata[15:0];
	end

	// ----------------------------------------
	// mode and launch
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			mode_q <= 1'b0;
		else if (apb_wr && idx == IDX_MODE)
			mode_q <= pwdata[MODE_BIT]; // RULE1 RULE2
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			start_q <= 1'b0;
		else if (apb_wr && idx == {2'b00, LOC_COUNT})
			start_q <= 1'b1; // RULE23
		else if (state_q == ST_IDLE)
			start_q <= 1'b0;
	end

	// ----------------------------------------
	// done flags, write one to clear, set wins
	// ----------------------------------------
	// ending is only by count; a zero byte never stops the block
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			done_q <= 1'b0;
		else if (term)
			done_q <= 1'b1; // RULE12 RULE20
		else if (apb_wr && idx == IDX_STATUS && pwdata[ST_DONE])
			done_q <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			front_q <= 1'b0;
		else if (term && ram_q[LOC_COUNT][CNT_IBIT])
			front_q <= 1'b1; // RULE13
		else if (apb_wr && idx == IDX_STATUS && pwdata[ST_FRONT])
			front_q <= 1'b0;
	end

	assign main_done_irq  = done_q;
	assign front_done_irq = front_q;

	// ----------------------------------------
	// control sequence
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			state_q <= ST_IDLE;
		else begin
			case (state_q)
				ST_IDLE: begin
					if (start_q)
						state_q <= ST_DLY_LOAD;
				end
				ST_DLY_LOAD: begin
					state_q <= ST_DLY_INC;
				end
				ST_DLY_INC: begin
					if (!dly_next[CNT_SIGN])
						state_q <= ST_BC_TEST; // RULE11
				end
				ST_BC_TEST: begin
					// count assumed loaded negative by software
					state_q <= term ? ST_IDLE : ST_BC_ADD; // RULE10 RULE12
				end
				ST_BC_ADD: begin
					state_q <= ST_ADR_FETCH;
				end
				ST_ADR_FETCH: begin
					state_q <= ST_BUS_READ;
				end
				ST_BUS_READ: begin
					if (front_rsp.ack)
						state_q <= ST_STORE;
				end
				ST_STORE: begin
					state_q <= ST_ADR_INC;
				end
				ST_ADR_INC: begin
					state_q <= ST_MAIN_WAIT; // RULE18
				end
				ST_MAIN_WAIT: begin
					if (main_read)
						state_q <= ST_DLY_LOAD; // RULE19
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// address and count register
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			abc_q <= RST_WORD;
		else begin
			case (state_q)
				ST_DLY_LOAD:  abc_q <= ram_q[LOC_DELAY]; // RULE22
				ST_DLY_INC:   abc_q <= dly_next; // RULE11
				ST_BC_TEST:   abc_q <= cnt_inc(ram_q[LOC_COUNT]); // RULE14
				ST_ADR_FETCH: abc_q <= ram_q[LOC_ADDR]; // RULE15
				ST_ADR_INC:   abc_q <= abc_q + step; // RULE8 RULE9
				default:      abc_q <= abc_q;
			endcase
		end
	end

	// ----------------------------------------
	// front bus fetch and placement
	// ----------------------------------------
	assign front_req.valid = state_q == ST_BUS_READ; // RULE15
	assign front_req.addr  = abc_q;

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			fetch_q <= RST_WORD;
		else if (state_q == ST_BUS_READ && front_rsp.ack)
			fetch_q <= place(mode_q, abc_q[0], front_rsp.data); // RULE3 RULE4 RULE5 RULE7
	end

	// ----------------------------------------
	// transfer buffer toward main
	// ----------------------------------------
	// slot 12 was written one cycle earlier, in the store step
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			ebuf_q <= '0;
		else if (state_q == ST_ADR_INC)
			ebuf_q[20:35] <= ram_q[LOC_DATA]; // RULE6 RULE7
	end

	assign main_data     = ebuf_q;
	assign main_item_req = state_q == ST_MAIN_WAIT; // RULE18

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence fetch_done_s;
		state_q == ST_BUS_READ && front_rsp.ack;
	endsequence

	sequence store_inc_s;
		state_q == ST_STORE ##1 state_q == ST_ADR_INC;
	endsequence

	mode_capture_a: assert property (apb_wr && idx == IDX_MODE |=> // RULE1
		mode_q == $past(pwdata[MODE_BIT]))
		else $error("mode flag not captured");

	word_place_a: assert property (fetch_done_s and mode_q |=> // RULE3
		fetch_q == $past(front_rsp.data))
		else $error("word not taken straight");

	even_byte_a: assert property (fetch_done_s and !mode_q && !abc_q[0] |=> // RULE4
		fetch_q == {8'h00, $past(front_rsp.data[7:0])})
		else $error("even byte misplaced");

	odd_swap_a: assert property (fetch_done_s and !mode_q && abc_q[0] |=> // RULE5
		fetch_q == {8'h00, $past(front_rsp.data[15:8])})
		else $error("odd byte not swapped");

	buf_copy_a: assert property (fetch_done_s ##1 store_inc_s |=> // RULE6
		main_data[20:35] == $past(fetch_q, 2) && main_data[0:19] == '0)
		else $error("buffer does not hold fetched item");

	addr_step_a: assert property (state_q == ST_ADR_INC |=> // RULE8
		abc_q == $past(abc_q) + (mode_q ? STEP_WORD : STEP_BYTE)
		&& ram_q[LOC_ADDR] == abc_q)
		else $error("address step wrong");

	delay_hold_a: assert property (state_q == ST_DLY_INC && dly_next[CNT_SIGN] |=> // RULE11
		state_q == ST_DLY_INC && abc_q == $past(dly_next))
		else $error("delay left early");

	term_a: assert property (term |=> state_q == ST_IDLE && done_q // RULE12
		&& front_q == ($past(ram_q[LOC_COUNT][CNT_IBIT]) || $past(front_q)))
		else $error("termination wrong");

	count_add_a: assert property (state_q == ST_BC_TEST && !term |=> // RULE14
		state_q == ST_BC_ADD ##1 ram_q[LOC_COUNT] == cnt_inc($past(ram_q[LOC_COUNT], 2)))
		else $error("count not written back");

	order_a: assert property ($rose(main_item_req) |-> // RULE18
		$past(state_q == ST_ADR_INC) && $past(state_q == ST_STORE, 2))
		else $error("main requested before fetch");

	release_a: assert property (main_item_req && main_read |=> // RULE19
		!main_item_req ##1 state_q == ST_DLY_INC)
		else $error("main not released");

	launch_a: assert property (state_q == ST_IDLE && start_q |=> // RULE23
		state_q == ST_DLY_LOAD ##1 abc_q == ram_q[LOC_DELAY])
		else $error("launch did not load delay");

endmodule
`default_nettype wire

// ### dv/front_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module front_mem_model
	import front_main_pkg::*;
(
	// clock and reset
	input  wire logic                          sys_clk,
	input  wire logic                          rstn,
	// answer delay in cycles
	input  wire logic [3:0]                    wait_cycles,
	// front bus
	input  wire front_main_pkg::front_req_type  front_req,
	output front_main_pkg::front_rsp_type      front_rsp
);
	import front_main_pkg::*;

	logic [3:0] lag_q;

	always_ff @(posedge sys_clk) begin
		if (!rstn || !front_req.valid || front_rsp.ack)
			lag_q <= 4'h0;
		else if (lag_q != wait_cycles)
			lag_q <= lag_q + 4'h1;
	end

	// data toggles when idle so a stale sample never matches by luck
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			front_rsp <= '0;
		else if (front_req.valid && !front_rsp.ack && lag_q == wait_cycles)
			front_rsp <= {1'b1, ~front_req.addr[7:0], front_req.addr[7:0]};
		else
			front_rsp <= {1'b0, ~front_rsp.data};
	end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import front_main_pkg::*;

	typedef struct packed {
		logic [3:0]  lag;
		logic        mode;
		logic [15:0] addr;
		logic [15:0] cnt;
		logic [15:0] end_addr;
		logic [15:0] last;
	} row_type;

	logic          sys_clk, rstn, psel, penable, pwrite, pready, pslverr, e;
	logic          main_item_req, main_read, main_done_irq, front_done_irq;
	logic [7:0]    paddr;
	logic [31:0]   pwdata, prdata, r;
	logic [0:35]   main_data;
	logic [3:0]    wait_cycles;
	logic [15:0]   a, w, it;
	front_req_type front_req;
	front_rsp_type front_rsp;
	row_type       rows [3];
	int            err_count, checks_done;

	front_to_main_transfer_engine dut (.sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .front_req(front_req), .front_rsp(front_rsp), .main_item_req(main_item_req),
		.main_read(main_read), .main_data(main_data), .main_done_irq(main_done_irq),
		.front_done_irq(front_done_irq));

	front_mem_model mem (.sys_clk(sys_clk), .rstn(rstn), .wait_cycles(wait_cycles),
		.front_req(front_req), .front_rsp(front_rsp));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task chk(input string nm, input logic [35:0] ex, input logic [35:0] got);
		checks_done++;
		if (got !== ex) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// request held until pready is seen high at a rising edge
	task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
		logic ok;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			ok = pready;
			r = prdata;
			e = pslverr;
		end while (ok !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_for(input logic sel);
		int n;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while ((sel ? main_done_irq : main_item_req) !== 1'b1 && n < 500);
		if (n >= 500) begin
			err_count++;
			$display("wrong value wait expected 1 seen 0");
		end
	endtask

	task give_verdict;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#200000;
		err_count++;
		give_verdict();
	end

	initial begin
		{rstn, psel, penable, pwrite, main_read} = '0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		wait_cycles = 4'h0;
		// end address and last item expected beside the inputs
		rows[0] = {4'h0, 1'b0, 16'h0100, 16'h3FFE, 16'h0102, 16'h00FE};
		rows[1] = {4'h3, 1'b0, 16'h0201, 16'h7FFE, 16'h0203, 16'h0002};
		rows[2] = {4'h1, 1'b1, 16'h0400, 16'h7FFE, 16'h0404, 16'hFD02};
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		apb(0, 8'h40, 32'h0);
		chk("mode", 36'h0, r);
		apb(0, 8'h44, 32'h0);
		chk("status", 36'h0, r);
		apb(1, 8'h3C, 32'hFFFF_A5C3);
		apb(0, 8'h3C, 32'h0);
		chk("ram", 36'h0_0000_A5C3, r);
		// ----------------------------------------
		// table of blocks, two items each
		// ----------------------------------------
		for (int i = 0; i < 3; i++) begin
			wait_cycles <= rows[i].lag;
			apb(1, 8'h40, {31'h0, rows[i].mode});
			// two delay passes, so the wait state really loops
			apb(1, 8'h00, 32'h0000_FFFE);
			apb(1, 8'h28, {16'h0, rows[i].addr});
			apb(1, 8'h18, {16'h0, rows[i].cnt});
			a = rows[i].addr;
			for (int k = 0; k < 2; k++) begin
				w = {~a[7:0], a[7:0]};
				it = rows[i].mode ? w : (a[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]});
				wait_for(1'b0);
				chk("main_data", {20'h0, it}, main_data);
				@(posedge sys_clk);
				main_read <= 1'b1;
				@(posedge sys_clk);
				main_read <= 1'b0;
				a = a + (rows[i].mode ? 16'h0002 : 16'h0001);
			end
			wait_for(1'b1);
			chk("front_irq", rows[i].cnt[14], front_done_irq);
			apb(0, 8'h28, 32'h0);
			chk("addr_slot", {20'h0, rows[i].end_addr}, r);
			apb(0, 8'h18, 32'h0);
			chk("count_slot", {16'h0, rows[i].cnt[15:14], 14'h0}, r);
			apb(0, 8'h30, 32'h0);
			chk("data_slot", {20'h0, rows[i].last}, r);
			apb(0, 8'h44, 32'h0);
			chk("status", {29'h0, rows[i].mode, rows[i].cnt[14], 1'b1}, r);
			apb(1, 8'h44, 32'h0000_0003);
		end
		// ----------------------------------------
		// awkward cases
		// ----------------------------------------
		apb(0, 8'h44, 32'h0);
		chk("cleared", 36'h4, r);
		apb(1, 8'h48, 32'hFFFF_FFFF);
		chk("slverr_wr", 36'h1, e);
		apb(0, 8'h48, 32'h0);
		chk("slverr_rd", 36'h1, e);
		chk("unmapped", 36'h0, r);
		// reset while an item waits for main; ram keeps its words
		apb(1, 8'h28, 32'h0000_0300);
		apb(1, 8'h18, 32'h0000_7FFE);
		wait_for(1'b0);
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		@(negedge sys_clk);
		chk("rst_item_req", 36'h0, main_item_req);
		chk("rst_main_data", 36'h0, main_data);
		chk("rst_done", 36'h0, main_done_irq);
		apb(0, 8'h44, 32'h0);
		chk("rst_status", 36'h0, r);
		apb(0, 8'h18, 32'h0);
		chk("ram_kept", 36'h0_0000_7FFF, r);
		apb(1, 8'h18, 32'h0000_0000);
		wait_for(1'b1);
		chk("no_item", 36'h0, main_item_req);
		chk("front_quiet", 36'h0, front_done_irq);
		give_verdict();
	end
endmodule
`default_nettype wire
